// ===== rtl/pse_event_dev.sv
module pse_event_dev
    import pse_evt_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Management link.
    pse_mgmt_if.dev         bus,
    // Per-channel discovery results, one-cycle pulses.
    input  wire logic [3:0] detect_done,
    input  wire logic [3:0] detect_changed,
    input  wire logic [3:0] class_done,
    input  wire logic [3:0] class_changed,
    // Per-channel fault pulses.
    input  wire logic [3:0] disconnect_evt,
    input  wire logic [3:0] overload_evt,
    input  wire logic [3:0] limit_evt,
    input  wire logic [3:0] start_evt,
    input  wire logic [3:0] chan_off,
    // Port configuration, one bit per channel pair, and the operating mode.
    input  wire logic [1:0] four_pair,
    input  wire logic [1:0] dual_sig,
    input  wire logic [1:0] power_on_pending,
    input  wire op_mode_t   op_mode,
    // Settings.
    input  wire logic       class_change_only_sel,
    input  wire logic       detect_change_only_sel,
    input  wire logic [3:0] overload_shutdown_dis,
    input  wire logic [4:0] irq_mask,
    input  wire logic       irq_global_allow,
    // Outputs to the rest of the controller.
    output logic            int_n,
    output logic      [4:0] summary,
    output logic      [3:0] power_on_request,
    output logic      [3:0] shutdown_req
);
    logic [7:0] det_q;
    logic [7:0] det_d;
    logic [7:0] flt_q;
    logic [7:0] flt_d;
    logic [7:0] sl_q;
    logic [7:0] sl_d;
    logic [7:0] det_set;
    logic [7:0] flt_set;
    logic [7:0] sl_set;
    logic [7:0] off_mask;
    logic       clr_det;
    logic       clr_flt;
    logic       clr_sl;
    logic [3:0] det_evt;
    logic [3:0] cls_evt;
    logic [3:0] det_fire;
    logic [3:0] cls_fire;
    logic [3:0] fp4;
    logic [3:0] ds4;
    logic [3:0] dis_set;
    logic [1:0] det_together;
    logic [1:0] cls_together;
    logic [4:0] summary_d;
    logic       rsp_valid_q;
    logic [7:0] rsp_data_q;
    logic [3:0] power_on_q;
    logic       int_n_q;
    logic [4:0] summary_q;
    logic [3:0] shutdown_q;

    ////////////////////////////////////////////////////////////////////////////
    // Discovery events and 4-pair aggregation.

    assign fp4 = {four_pair[1], four_pair[1], four_pair[0], four_pair[0]};
    assign ds4 = {dual_sig[1], dual_sig[1], dual_sig[0], dual_sig[0]};

    assign cls_evt = class_done & (~{4{class_change_only_sel}} | class_changed);
    assign det_evt = detect_done & (~{4{detect_change_only_sel}} | detect_changed);

    // Merged results are released in the cycle the second channel completes,
    // well inside the 5 ms allowance, so no wait timer is needed.
    for (genvar p = 0; p < 2; p++)
    begin : g_port
        // Auto mode with a dual-signature load runs a staggered turn-on.
        assign det_together[p] = four_pair[p] && !power_on_pending[p]
                                 && !(dual_sig[p] && op_mode == MODE_AUTO);
        // A single-signature load classifies on one pair only, so never waits.
        assign cls_together[p] = four_pair[p] && dual_sig[p] && !power_on_pending[p]
                                 && op_mode == MODE_SEMI;

        pse_pair_merge u_det_merge
        (
            .pclk     (pclk),
            .presetn  (presetn),
            .done     (det_evt[2*p +: 2]),
            .together (det_together[p]),
            .off      (chan_off[2*p +: 2]),
            .set      (det_fire[2*p +: 2])
        );

        pse_pair_merge u_cls_merge
        (
            .pclk     (pclk),
            .presetn  (presetn),
            .done     (cls_evt[2*p +: 2]),
            .together (cls_together[p]),
            .off      (chan_off[2*p +: 2]),
            .set      (cls_fire[2*p +: 2])
        );
    end

    assign det_set = {cls_fire, det_fire};

    ////////////////////////////////////////////////////////////////////////////
    // Fault events.

    // A single-signature disconnect is mirrored onto the partner channel.
    assign dis_set = disconnect_evt
                     | ({disconnect_evt[2], disconnect_evt[3],
                         disconnect_evt[0], disconnect_evt[1]} & fp4 & ~ds4);
    // Overload flags follow each channel's own timeout pulse.
    assign flt_set = {dis_set, overload_evt};
    assign sl_set  = {limit_evt, start_evt};

    ////////////////////////////////////////////////////////////////////////////
    // Command decode.

    always_comb
    begin
        clr_det = 1'b0;
        clr_flt = 1'b0;
        clr_sl  = 1'b0;
        if (bus.cmd_valid && !bus.cmd_write)
        begin
            clr_det = bus.cmd_code == CMD_DET_CLEAR;
            clr_flt = bus.cmd_code == CMD_FLT_CLEAR;
            clr_sl  = bus.cmd_code == CMD_SL_CLEAR;
        end
    end

    assign off_mask = {chan_off, chan_off};

    // A new event wins over both the read clear and the turn-off clear.
    assign det_d = (det_q & ~{8{clr_det}} & ~off_mask) | det_set;
    assign flt_d = (flt_q & ~{8{clr_flt}} & ~off_mask) | flt_set;
    assign sl_d  = (sl_q  & ~{8{clr_sl}}  & ~off_mask) | sl_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            det_q <= EVENT_RESET;
            flt_q <= EVENT_RESET;
            sl_q  <= EVENT_RESET;
        end
        else
        begin
            det_q <= det_d;
            // Only the flag is cleared; the timeout counters live elsewhere.
            flt_q <= flt_d;
            sl_q  <= sl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link answer: the old value is returned by both aliases.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= UNMAPPED_DATA;
        end
        else
        begin
            rsp_valid_q <= bus.cmd_valid;
            if (bus.cmd_valid && !bus.cmd_write)
            begin
                unique case (bus.cmd_code)
                    CMD_DET_VIEW, CMD_DET_CLEAR: rsp_data_q <= det_q;
                    CMD_FLT_VIEW, CMD_FLT_CLEAR: rsp_data_q <= flt_q;
                    CMD_SL_VIEW,  CMD_SL_CLEAR:  rsp_data_q <= sl_q;
                    default:                     rsp_data_q <= UNMAPPED_DATA;
                endcase
            end
            else if (bus.cmd_valid)
            begin
                rsp_data_q <= UNMAPPED_DATA;
            end
        end
    end

    assign bus.rsp_valid = rsp_valid_q;
    assign bus.rsp_data  = rsp_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // Power-on requests written by the host.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            power_on_q <= 4'h0;
        else if (bus.cmd_valid && bus.cmd_write && bus.cmd_code == CMD_POWER_ON)
            power_on_q <= bus.cmd_wdata[3:0];
        else
            power_on_q <= 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overload shutdown: a channel with shutdown disabled stays powered.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shutdown_q <= 4'h0;
        else
            shutdown_q <= overload_evt & ~overload_shutdown_dis;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summary and interrupt, computed from next flag values so that a
    // clear-on-read drops the pin in the same edge as the flags.

    always_comb
    begin
        summary_d            = SUM_RESET;
        summary_d[SUM_DET]   = |det_d[LO_LSB +: 4];
        summary_d[SUM_CLS]   = |det_d[HI_LSB +: 4];
        summary_d[SUM_DIS]   = |flt_d[HI_LSB +: 4];
        summary_d[SUM_FAULT] = |flt_d[LO_LSB +: 4] | |sl_d[HI_LSB +: 4];
        summary_d[SUM_START] = |sl_d[LO_LSB +: 4];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            summary_q <= SUM_RESET;
            int_n_q   <= 1'b1;
        end
        else
        begin
            summary_q <= summary_d;
            int_n_q   <= !(irq_global_allow && |(summary_d & irq_mask));
        end
    end

    assign int_n            = int_n_q;
    assign summary          = summary_q;
    assign power_on_request = power_on_q;
    assign shutdown_req     = shutdown_q;

endmodule : pse_event_dev

// ===== rtl/pse_evt_pkg.sv
package pse_evt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes on the management link.
    localparam logic [7:0] CMD_DET_VIEW   = 8'h04;
    localparam logic [7:0] CMD_DET_CLEAR  = 8'h05;
    localparam logic [7:0] CMD_FLT_VIEW   = 8'h06;
    localparam logic [7:0] CMD_FLT_CLEAR  = 8'h07;
    localparam logic [7:0] CMD_SL_VIEW    = 8'h08;
    localparam logic [7:0] CMD_SL_CLEAR   = 8'h09;
    localparam logic [7:0] CMD_POWER_ON   = 8'h19;
    localparam logic [7:0] CMD_ALLOC      = 8'h29;
    localparam logic [7:0] EVENT_RESET    = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions inside each event register.
    localparam int HI_LSB = 4;
    localparam int LO_LSB = 0;

    // Summary bit positions and mask positions.
    localparam int SUM_DET   = 0;
    localparam int SUM_CLS   = 1;
    localparam int SUM_DIS   = 2;
    localparam int SUM_FAULT = 3;
    localparam int SUM_START = 4;
    localparam logic [4:0] SUM_RESET = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Host APB register map.
    localparam logic [31:0] HOST_CMD_OFS    = 32'h0000_0000;
    localparam logic [31:0] HOST_STAT_OFS   = 32'h0000_0004;
    localparam int          CMD_CODE_LSB    = 0;
    localparam int          CMD_WDATA_LSB   = 8;
    localparam int          CMD_WRITE_BIT   = 16;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_RDATA_LSB  = 8;
    localparam logic [31:0] HOST_CMD_RESET  = 32'h0000_0000;
    localparam logic [31:0] APB_READ_RESET  = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        MODE_MANUAL = 2'b00,
        MODE_SEMI   = 2'b01,
        MODE_AUTO   = 2'b11
    } op_mode_t;

    typedef enum logic [1:0]
    {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_WAIT = 2'b11
    } host_state_t;

endpackage : pse_evt_pkg

// ===== rtl/pse_mgmt_if.sv
interface pse_mgmt_if;
    logic       cmd_valid;
    logic       cmd_write;
    logic [7:0] cmd_code;
    logic [7:0] cmd_wdata;
    logic       rsp_valid;
    logic [7:0] rsp_data;

    modport dev
    (
        input  cmd_valid,
        input  cmd_write,
        input  cmd_code,
        input  cmd_wdata,
        output rsp_valid,
        output rsp_data
    );

    modport host
    (
        output cmd_valid,
        output cmd_write,
        output cmd_code,
        output cmd_wdata,
        input  rsp_valid,
        input  rsp_data
    );
endinterface : pse_mgmt_if

// ===== rtl/pse_pair_merge.sv
module pse_pair_merge
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Per-channel completion pulses of one port.
    input  wire logic [1:0] done,
    input  wire logic       together,
    input  wire logic [1:0] off,
    // Flag set pulses.
    output logic      [1:0] set
);
    logic [1:0] pend_q;
    logic [1:0] pend_d;

    // A channel turned off forgets a result that was still waiting for its partner.
    assign pend_d = (pend_q | done) & ~off;
    assign set    = together ? ((&pend_d) ? 2'b11 : 2'b00) : done;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_q <= 2'b00;
        else if (together && !(&pend_d))
            pend_q <= pend_d;
        else
            pend_q <= 2'b00;
    end
endmodule : pse_pair_merge

// ===== rtl/pse_event_host.sv
module pse_event_host
    import pse_evt_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Management link.
    pse_mgmt_if.host         bus
);
    host_state_t state_q;
    logic [31:0] cmd_q;
    logic [7:0]  rdata_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        setup;
    logic        access;
    logic        hit_cmd;
    logic        hit_stat;
    logic        launch;

    assign setup    = psel && !penable && !pready_q;
    assign access   = psel && penable && pready_q;
    assign hit_cmd  = paddr == HOST_CMD_OFS;
    assign hit_stat = paddr == HOST_STAT_OFS;
    // A command written while one is still in flight is dropped.
    assign launch   = access && pwrite && hit_cmd && state_q == H_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait-free access phase, outputs from flip-flops.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= APB_READ_RESET;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !hit_cmd && !hit_stat;
            if (setup && !pwrite)
            begin
                prdata_q <= APB_READ_RESET;
                if (hit_cmd)
                    prdata_q <= cmd_q;
                else if (hit_stat)
                begin
                    prdata_q[STAT_BUSY_BIT]        <= state_q != H_IDLE;
                    prdata_q[STAT_RDATA_LSB +: 8]  <= rdata_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= H_IDLE;
            cmd_q   <= HOST_CMD_RESET;
            rdata_q <= EVENT_RESET;
        end
        else
        begin
            unique case (state_q)
                H_IDLE:
                begin
                    if (launch)
                    begin
                        cmd_q   <= pwdata;
                        state_q <= H_SEND;
                    end
                end
                H_SEND:
                begin
                    state_q <= H_WAIT;
                end
                H_WAIT:
                begin
                    if (bus.rsp_valid)
                    begin
                        rdata_q <= bus.rsp_data;
                        state_q <= H_IDLE;
                    end
                end
                default:
                begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    // Re-powering one channel is a write of its bit to the power-on code.
    assign bus.cmd_valid = state_q == H_SEND;
    assign bus.cmd_write = cmd_q[CMD_WRITE_BIT];
    assign bus.cmd_code  = cmd_q[CMD_CODE_LSB +: 8];
    assign bus.cmd_wdata = cmd_q[CMD_WDATA_LSB +: 8];

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

endmodule : pse_event_host

// ===== verif/pse_evt_props.sv
module pse_evt_props
    import pse_evt_pkg::*;
(
    // Clock and reset.
    input wire logic       pclk,
    input wire logic       presetn,
    // Management link.
    input wire logic       cmd_valid,
    input wire logic       cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [7:0] cmd_wdata,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    a_rsp_next_cycle: assert property (cmd_valid |=> rsp_valid)
        else $error("answer missing one cycle after a command");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("answer without a command");
    a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer strobe longer than one cycle");
    a_cmd_spacing: assert property (cmd_valid |=> !cmd_valid [*2])
        else $error("commands closer than three cycles");
    a_cmd_held: assert property (cmd_valid |=> $stable(cmd_code) && $stable(cmd_write))
        else $error("command code changed under its answer");
    a_data_stands: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("answer data moved without an answer strobe");
    a_write_zero: assert property (cmd_valid && cmd_write |=> rsp_data == 8'h00)
        else $error("write answered with nonzero data");
    // Codes above the clear alias, other than the power and allocation slots, hold nothing.
    a_unmapped_zero: assert property (cmd_valid && !cmd_write && cmd_code > CMD_SL_CLEAR
        && cmd_code != CMD_POWER_ON && cmd_code != CMD_ALLOC |=> rsp_data == UNMAPPED_DATA)
        else $error("unmapped code answered with nonzero data");

    c_clear: cover property (cmd_valid && cmd_code == CMD_DET_CLEAR);
    c_power_on: cover property (cmd_valid && cmd_write && cmd_code == CMD_POWER_ON);
    c_data: cover property (rsp_valid && rsp_data != 8'h00);
endmodule : pse_evt_props

// ===== verif/pse_channel_event_flag_registers_tb.sv
module pse_channel_event_flag_registers_tb
    import pse_evt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [35:0] ev;
    logic [1:0]  four_pair;
    logic [1:0]  dual_sig;
    logic [1:0]  power_on_pending;
    op_mode_t    op_mode;
    logic        class_change_only_sel;
    logic        detect_change_only_sel;
    logic [3:0]  ovl_dis;
    logic [4:0]  irq_mask;
    logic        irq_global_allow;
    logic        int_n;
    logic [4:0]  summary;
    logic [3:0]  power_on_request;
    logic [3:0]  shutdown_req;
    logic [3:0]  pwr_seen;
    logic [3:0]  sd_seen;
    logic [7:0]  r;
    int          fail_count;
    int          total_checks;

    pse_mgmt_if link ();

    pse_event_host u_pse_event_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link));

    pse_event_dev u_pse_event_dev (.pclk(pclk), .presetn(presetn), .bus(link),
        .detect_done(ev[3:0]), .detect_changed(ev[7:4]), .class_done(ev[11:8]),
        .class_changed(ev[15:12]), .disconnect_evt(ev[19:16]), .overload_evt(ev[23:20]),
        .limit_evt(ev[27:24]), .start_evt(ev[31:28]), .chan_off(ev[35:32]),
        .four_pair(four_pair), .dual_sig(dual_sig), .power_on_pending(power_on_pending),
        .op_mode(op_mode), .class_change_only_sel(class_change_only_sel),
        .detect_change_only_sel(detect_change_only_sel), .overload_shutdown_dis(ovl_dis),
        .irq_mask(irq_mask), .irq_global_allow(irq_global_allow), .int_n(int_n),
        .summary(summary), .power_on_request(power_on_request), .shutdown_req(shutdown_req));

    pse_evt_props u_props (.pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
        .cmd_write(link.cmd_write), .cmd_code(link.cmd_code), .cmd_wdata(link.cmd_wdata),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

    always #5 pclk = ~pclk;

    // Pulses are only one cycle wide, so they are gathered into sticky records.
    always @(posedge pclk)
    begin
        if (!presetn)
        begin
            pwr_seen <= 4'h0;
            sd_seen  <= 4'h0;
        end
        else
        begin
            pwr_seen <= pwr_seen | power_on_request;
            sd_seen  <= sd_seen | shutdown_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task results;
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
             input logic [35:0] sev, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        ev      <= '0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            fail_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // An event launched here meets the command on the link in the same cycle.
        ev      <= sev;
    endtask : apb

    task host_cmd(input logic [7:0] code, input logic [7:0] wd, input logic wr,
                  input logic [35:0] sev, output logic [7:0] rsp);
        logic [31:0] rd;
        logic        err;
        int          n;
        apb(1'b1, HOST_CMD_OFS, {15'h0000, wr, wd, code}, sev, rd, err);
        n = 0;
        do
        begin
            apb(1'b0, HOST_STAT_OFS, 32'h0000_0000, 36'h0_0000_0000, rd, err);
            n++;
        end
        while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 20);
        if (rd[STAT_BUSY_BIT] !== 1'b0)
        begin
            fail_count++;
            results();
        end
        rsp = rd[STAT_RDATA_LSB +: 8];
    endtask : host_cmd

    task rd_chk(input logic [7:0] code, input logic [7:0] exp);
        host_cmd(code, 8'h00, 1'b0, 36'h0_0000_0000, r);
        check(r, exp);
    endtask : rd_chk

    task fire(input logic [35:0] v);
        @(posedge pclk);
        ev <= v;
        @(posedge pclk);
        ev <= '0;
        @(negedge pclk);
    endtask : fire

    // The view is read first, so a matching clear afterwards proves the view left it alone.
    task ev_chk(input logic [35:0] v, input logic [7:0] code, input logic [7:0] exp);
        fire(v);
        rd_chk(code, exp);
        rd_chk(code + 8'h01, exp);
        rd_chk(code, 8'h00);
    endtask : ev_chk

    task cfg(input logic [1:0] fp, input logic [1:0] ds, input logic [1:0] pw,
             input op_mode_t md, input logic [3:0] dis);
        @(posedge pclk);
        four_pair        <= fp;
        dual_sig         <= ds;
        power_on_pending <= pw;
        op_mode          <= md;
        ovl_dis          <= dis;
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        logic [31:0] rd;
        logic        err;
        @(negedge pclk);
        check(int_n, 1'b1);
        check(summary, SUM_RESET);
        for (int i = 0; i < 3; i++)
            rd_chk(CMD_DET_VIEW + 8'(2 * i), EVENT_RESET);
        rd_chk(8'h0A, UNMAPPED_DATA);
        apb(1'b0, 32'h0000_0010, 32'h0000_0000, 36'h0_0000_0000, rd, err);
        check(err, 1'b1);
        check(rd, APB_READ_RESET);
    endtask : t_reset

    task t_fields;
        logic [35:0] v [3];
        logic [7:0]  e [3];
        logic [4:0]  s [3];
        v = '{36'h0_0000_0801, 36'h0_0042_0000, 36'h0_8100_0000};
        e = '{8'h81, 8'h24, 8'h18};
        s = '{5'h03, 5'h0C, 5'h18};
        for (int i = 0; i < 3; i++)
        begin
            fire(v[i]);
            check(summary, s[i]);
            check(int_n, 1'b0);
            ev_chk(36'h0_0000_0000, CMD_DET_VIEW + 8'(2 * i), e[i]);
            @(negedge pclk);
            check(int_n, 1'b1);
            check(summary, SUM_RESET);
        end
    endtask : t_fields

    task t_mask;
        @(posedge pclk);
        irq_mask <= 5'h1E;
        fire(36'h0_0000_0001);
        check(summary, 5'h01);
        check(int_n, 1'b1);
        @(posedge pclk);
        irq_mask         <= 5'h1F;
        irq_global_allow <= 1'b0;
        fire(36'h0_0000_0000);
        check(int_n, 1'b1);
        @(posedge pclk);
        irq_global_allow <= 1'b1;
        fire(36'h0_0000_0000);
        check(int_n, 1'b0);
        rd_chk(CMD_DET_CLEAR, 8'h01);
    endtask : t_mask

    task t_pair;
        cfg(2'b01, 2'b00, 2'b00, MODE_SEMI, 4'h0);
        fire(36'h0_0000_0001);
        rd_chk(CMD_DET_VIEW, 8'h00);
        ev_chk(36'h0_0000_0002, CMD_DET_VIEW, 8'h03);
        ev_chk(36'h0_0000_0100, CMD_DET_VIEW, 8'h10);
        ev_chk(36'h0_0001_0000, CMD_FLT_VIEW, 8'h30);
        ev_chk(36'h0_0010_0000, CMD_FLT_VIEW, 8'h01);
        cfg(2'b01, 2'b00, 2'b01, MODE_SEMI, 4'h0);
        ev_chk(36'h0_0000_0001, CMD_DET_VIEW, 8'h01);
        cfg(2'b01, 2'b01, 2'b00, MODE_SEMI, 4'h0);
        fire(36'h0_0000_0100);
        rd_chk(CMD_DET_VIEW, 8'h00);
        ev_chk(36'h0_0000_0200, CMD_DET_VIEW, 8'h30);
        cfg(2'b01, 2'b01, 2'b00, MODE_MANUAL, 4'h0);
        ev_chk(36'h0_0000_0100, CMD_DET_VIEW, 8'h10);
        cfg(2'b01, 2'b01, 2'b00, MODE_AUTO, 4'h0);
        ev_chk(36'h0_0000_0101, CMD_DET_VIEW, 8'h11);
        ev_chk(36'h0_0001_0000, CMD_FLT_VIEW, 8'h10);
        cfg(2'b00, 2'b00, 2'b00, MODE_MANUAL, 4'h0);
    endtask : t_pair

    task t_misc;
        cfg(2'b00, 2'b00, 2'b00, MODE_MANUAL, 4'h1);
        ev_chk(36'h0_0010_0000, CMD_FLT_VIEW, 8'h01);
        check(sd_seen, 4'h0);
        cfg(2'b00, 2'b00, 2'b00, MODE_MANUAL, 4'h0);
        ev_chk(36'h0_0010_0000, CMD_FLT_VIEW, 8'h01);
        check(sd_seen, 4'h1);
        class_change_only_sel  <= 1'b1;
        detect_change_only_sel <= 1'b1;
        ev_chk(36'h0_0000_0101, CMD_DET_VIEW, 8'h00);
        ev_chk(36'h0_0000_1111, CMD_DET_VIEW, 8'h11);
        class_change_only_sel  <= 1'b0;
        detect_change_only_sel <= 1'b0;
        fire(36'h0_0606_0006);
        fire(36'h2_0000_0000);
        rd_chk(CMD_DET_CLEAR, 8'h04);
        rd_chk(CMD_FLT_CLEAR, 8'h40);
        rd_chk(CMD_SL_CLEAR, 8'h40);
        fire(36'h0_0000_0001);
        host_cmd(CMD_DET_CLEAR, 8'h00, 1'b0, 36'h0_0000_0002, r);
        check(r, 8'h01);
        rd_chk(CMD_DET_CLEAR, 8'h02);
        host_cmd(CMD_POWER_ON, 8'h02, 1'b1, 36'h0_0000_0000, r);
        check(r, 8'h00);
        check(pwr_seen, 4'h2);
    endtask : t_misc

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata, ev} = '0;
        {four_pair, dual_sig, power_on_pending, ovl_dis} = '0;
        op_mode = MODE_MANUAL;
        class_change_only_sel = 0;
        detect_change_only_sel = 0;
        irq_mask = 5'h1F;
        irq_global_allow = 1;
        fail_count = 0;
        total_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_misc();
        t_fields();
        t_mask();
        t_pair();
        results();
    end
endmodule : pse_channel_event_flag_registers_tb
